/* hdl/vo_regs.svh */
// Constants for the video overlay inserter: field widths, limits, levels
`ifndef VO_REGS_SVH
`define VO_REGS_SVH

// Pixel sample and raster coordinate widths
`define VO_PIX_W 10
`define VO_COORD_W 12
// Percentage fields, 0..100 held in 7 bits
`define VO_PCT_W 7
`define VO_PCT_FULL 7'h64
`define VO_BOX_PCT_MAX 7'h28
// Speed field width, pixels or lines per frame
`define VO_SPEED_W 4
// Alpha field, 0 transparent .. 0x100 opaque
`define VO_ALPHA_W 9
`define VO_ALPHA_FULL 9'h100
// Drawn levels for the graticule line
`define VO_GRAT_LUMA 10'h3AC
`define VO_GRAT_CHROMA 10'h200
// Blanking level used when outputs are disabled
`define VO_BLANK_LUMA 10'h040
`define VO_BLANK_CHROMA 10'h200
// Number of video paths
`define VO_PATHS 2

`endif

/* hdl/vo_pkg.sv */
// Types shared by the video overlay inserter
package vo_pkg;
	`include "vo_regs.svh"

	// One pixel sample: luma and chroma
	typedef struct packed {
		logic [`VO_PIX_W-1:0] luma;
		logic [`VO_PIX_W-1:0] chroma;
	} vo_pix_s;

	// Raster timing beside a pixel
	typedef struct packed {
		logic valid;
		logic sof;
		logic [`VO_COORD_W-1:0] x;
		logic [`VO_COORD_W-1:0] y;
	} vo_pos_s;

	// Keyer mode
	typedef enum logic [1:0] {
		VO_KEY_OFF = 2'b00,
		VO_KEY_THRESH = 2'b01,
		VO_KEY_REV = 2'b10,
		VO_KEY_RAMP = 2'b11
	} vo_key_mode_e;

	// Moving box settings of one path
	typedef struct packed {
		logic enable;
		logic only_on_loss;
		logic [`VO_PCT_W-1:0] width_pct;
		logic [`VO_PCT_W-1:0] height_pct;
		logic [`VO_SPEED_W-1:0] speed_x;
		logic [`VO_SPEED_W-1:0] speed_y;
		vo_pix_s color;
	} vo_box_cfg_s;

	// Overlay settings of one path
	typedef struct packed {
		logic sdi_master_en;
		logic composite_video_output_master_en;
		logic saa_en;
		logic [`VO_PCT_W-1:0] saa_height_pct;
		logic [`VO_PCT_W-1:0] saa_width_pct;
		logic loss_disables_out;
		vo_key_mode_e key_mode;
		logic [`VO_PIX_W-1:0] key_threshold;
		logic [`VO_ALPHA_W-1:0] key_alpha;
	} vo_ovl_cfg_s;

	// Raster size of the current format
	typedef struct packed {
		logic [`VO_COORD_W-1:0] width;
		logic [`VO_COORD_W-1:0] height;
	} vo_raster_s;
endpackage

/* hdl/vo_moving_box.sv */
// Moving box position tracker for one video path
`timescale 1ns/1ps
module vo_moving_box
	import vo_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Settings and frame timing
	input wire vo_box_cfg_s cfg,
	input wire vo_raster_s raster,
	input wire logic frame_tick,
	// Box rectangle
	output vo_raster_s box_origin,
	output vo_raster_s box_size
);
	// All state in one struct
	typedef struct packed {
		logic [`VO_COORD_W-1:0] px;
		logic [`VO_COORD_W-1:0] py;
		logic dir_x;
		logic dir_y;
	} vo_mb_state_s;

	vo_mb_state_s st_r;
	vo_mb_state_s st_nxt;
	logic [`VO_COORD_W-1:0] bw;
	logic [`VO_COORD_W-1:0] bh;

	// Percentage of raster, clamped to the 40 percent ceiling
	function automatic logic [`VO_COORD_W-1:0] pct_of(
		input logic [`VO_PCT_W-1:0] pct,
		input logic [`VO_COORD_W-1:0] full);
		logic [`VO_PCT_W-1:0] p;
		logic [`VO_COORD_W+`VO_PCT_W-1:0] prod;
		p = (pct > `VO_BOX_PCT_MAX) ? `VO_BOX_PCT_MAX : pct;
		prod = full * p;
		pct_of = `VO_COORD_W'(prod / `VO_PCT_FULL);
	endfunction

	// Step one axis, bouncing off both edges
	function automatic logic [`VO_COORD_W:0] step(
		input logic [`VO_COORD_W-1:0] pos,
		input logic dir,
		input logic [`VO_SPEED_W-1:0] spd,
		input logic [`VO_COORD_W-1:0] lim);
		logic [`VO_COORD_W:0] n;
		n = {1'b0, pos};
		if (!dir) begin
			// Moving forward; reverse at far edge
			if ({1'b0, pos} + spd >= {1'b0, lim}) begin
				n = {1'b1, lim};
			end else begin
				n = {1'b0, pos + `VO_COORD_W'(spd)};
			end
		end else begin
			// Moving back; reverse at zero
			if (pos <= `VO_COORD_W'(spd)) begin
				n = {1'b0, `VO_COORD_W'(0)};
			end else begin
				n = {1'b1, pos - `VO_COORD_W'(spd)};
			end
		end
		step = n;
	endfunction

	// Box size from raster and settings
	always_comb begin
		bw = pct_of(cfg.width_pct, raster.width); // R7
		bh = pct_of(cfg.height_pct, raster.height); // R7
	end

	// Once per frame advance, independent of picture content
	always_comb begin
		logic [`VO_COORD_W:0] sx;
		logic [`VO_COORD_W:0] sy;
		sx = '0;
		sy = '0;
		st_nxt = st_r;
		if (frame_tick) begin
			sx = step(st_r.px, st_r.dir_x, cfg.speed_x, raster.width - bw); // R9
			sy = step(st_r.py, st_r.dir_y, cfg.speed_y, raster.height - bh);
			st_nxt.px = sx[`VO_COORD_W-1:0]; // R15
			st_nxt.dir_x = sx[`VO_COORD_W]; // R15
			st_nxt.py = sy[`VO_COORD_W-1:0]; // R10
			st_nxt.dir_y = sy[`VO_COORD_W]; // R15
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Rectangle out
	always_comb begin
		box_origin.width = st_r.px;
		box_origin.height = st_r.py;
		box_size.width = bw;
		box_size.height = bh;
	end
endmodule

/* hdl/vo_overlay_inserter.sv */
// Two-path overlay inserter: graticule, moving box, luma keyer
// Notes on behaviour
// [R1] Separate master enables for digital and composite
// [R2] Master enable off suppresses every overlay; code removes markers only, keyer still applies
// [R3] All enabled markers drawn together
// [R4] Graticule needs own enable plus master
// [R5] Graticule height and width percent of 4:3
// [R6] Box continuous or only on input loss
// [R7] Box size zero to forty percent raster
// [R8] Disabled-output loss blanks raster and box
// [R9] Separate horizontal and vertical box speeds
// [R10] Box colour settable; moves on static picture
// [R11] Each path has its own box settings
// [R12] Lower key threshold keys wider luma range
// [R13] Larger alpha gives more opaque fill
// [R14] Threshold, reverse threshold and ramp modes
// [R15] Box steps per frame, bounces at edges
//
// Pipeline: one register stage, inputs to outputs
// Position words travel beside the pixel, unchanged unless loss blanking drops valid
// Config sampled every edge, no shadow copies
// Hazard: config change mid-line shows at once
// User should change settings during blanking
//
// Keyer: decision per pixel from key luma
// Threshold mode keys when key above level
// Reverse mode keys when key below level
// Ramp mode scales alpha by key luma
// Ramp product kept wide before the shift
// A narrow product would wrap above mid key
// Blend divides by 256 with a shift
// Alpha above full clamps to opaque
//
// Markers: graticule over box over keyed video
// Graticule is a one pixel outline
// Outline centred in the centred 4:3 area
// Narrow rasters clamp the 4:3 width
// Zero height or width draws nothing
//
// Box: position from a tracker per path
// Tracker advances on first pixel of frame
// Box at origin after reset
// Box drawn only while loss rule allows
//
// Loss: pin crosses clocks, two flip-flops
// Only the second stage feeds any logic
// Disabled outputs drop valid and blank pixel
// Blanking wins over every marker
//
// Masters: each output gated on its own
// Master off keeps keyer, removes markers
// Trade-off: both outputs share one keyer
// So keyed picture matches on both outputs
//
// Reset: synchronous, clears all outputs
// Outputs read straight from the state register
`timescale 1ns/1ps
module vo_overlay_inserter
	import vo_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Raster format per path
	input wire vo_raster_s raster [`VO_PATHS],
	// Program video per path, with position
	input wire vo_pix_s prog_pix [`VO_PATHS],
	input wire vo_pos_s prog_pos [`VO_PATHS],
	// Key and fill per path, aligned to program
	input wire vo_pix_s key_pix [`VO_PATHS],
	input wire vo_pix_s fill_pix [`VO_PATHS],
	// Input loss pin per path
	input wire logic input_signal_loss [`VO_PATHS],
	// Settings per path
	input wire vo_ovl_cfg_s ovl_cfg [`VO_PATHS],
	input wire vo_box_cfg_s box_cfg [`VO_PATHS],
	// Digital output per path
	output vo_pix_s sdi_pix [`VO_PATHS],
	output vo_pos_s sdi_pos [`VO_PATHS],
	// Composite output per path
	output vo_pix_s composite_video_output_pix [`VO_PATHS],
	output vo_pos_s composite_video_output_pos [`VO_PATHS],
	// Loss status per path, synchronised
	output logic loss_seen [`VO_PATHS]
);
	// Per-path register state
	typedef struct packed {
		logic loss_meta;
		logic loss_sync;
		vo_pix_s sdi_pix;
		vo_pos_s sdi_pos;
		vo_pix_s cv_pix;
		vo_pos_s cv_pos;
	} vo_path_state_s;

	// Whole module state in one struct
	typedef struct packed {
		vo_path_state_s [`VO_PATHS-1:0] p;
	} vo_state_s;

	vo_state_s st_r;
	vo_state_s st_nxt;

	// Box rectangles from the trackers
	vo_raster_s box_org [`VO_PATHS];
	vo_raster_s box_sz [`VO_PATHS];

	// Scale a coordinate by a percent (0..100)
	function automatic logic [`VO_COORD_W-1:0] scale_pct(
		input logic [`VO_COORD_W-1:0] full,
		input logic [`VO_PCT_W-1:0] pct);
		logic [`VO_PCT_W-1:0] p;
		logic [`VO_COORD_W+`VO_PCT_W-1:0] prod;
		p = (pct > `VO_PCT_FULL) ? `VO_PCT_FULL : pct;
		prod = full * p;
		scale_pct = `VO_COORD_W'(prod / `VO_PCT_FULL);
	endfunction

	// Inside a rectangle test, used for box and graticule
	function automatic logic in_rect(
		input logic [`VO_COORD_W-1:0] x,
		input logic [`VO_COORD_W-1:0] y,
		input logic [`VO_COORD_W-1:0] x0,
		input logic [`VO_COORD_W-1:0] y0,
		input logic [`VO_COORD_W-1:0] w,
		input logic [`VO_COORD_W-1:0] h);
		logic [`VO_COORD_W:0] xe;
		logic [`VO_COORD_W:0] ye;
		xe = {1'b0, x0} + {1'b0, w};
		ye = {1'b0, y0} + {1'b0, h};
		in_rect = ({1'b0, x} >= {1'b0, x0}) && ({1'b0, x} < xe) &&
			({1'b0, y} >= {1'b0, y0}) && ({1'b0, y} < ye);
	endfunction

	// Blend one component: prog + alpha*(fill-prog)/256
	function automatic logic [`VO_PIX_W-1:0] blend(
		input logic [`VO_PIX_W-1:0] a,
		input logic [`VO_PIX_W-1:0] b,
		input logic [`VO_ALPHA_W-1:0] al);
		logic [`VO_ALPHA_W-1:0] k;
		logic [`VO_PIX_W+`VO_ALPHA_W:0] sum;
		k = (al > `VO_ALPHA_FULL) ? `VO_ALPHA_FULL : al;
		sum = a * (`VO_ALPHA_FULL - k) + b * k;
		blend = `VO_PIX_W'(sum >> (`VO_ALPHA_W - 1));
	endfunction

	// One box tracker per path, each fed its own settings
	genvar gi;
	generate
		for (gi = 0; gi < `VO_PATHS; gi++) begin : g_box
			vo_moving_box u_box (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.cfg(box_cfg[gi]), // R11
				.raster(raster[gi]),
				.frame_tick(prog_pos[gi].valid && prog_pos[gi].sof),
				.box_origin(box_org[gi]),
				.box_size(box_sz[gi])
			);
		end
	endgenerate

	// Next state: keyer, markers and output gating per path
	always_comb begin
		vo_pix_s keyed;
		vo_pix_s marked;
		logic [`VO_COORD_W-1:0] w43;
		logic [`VO_COORD_W-1:0] x43;
		logic [`VO_COORD_W-1:0] gw;
		logic [`VO_COORD_W-1:0] gh;
		logic [`VO_COORD_W-1:0] gx;
		logic [`VO_COORD_W-1:0] gy;
		logic [`VO_COORD_W-1:0] px;
		logic [`VO_COORD_W-1:0] py;
		logic on_edge;
		logic grat_hit;
		logic box_hit;
		logic key_on;
		logic [`VO_ALPHA_W-1:0] ramp;
		logic loss;
		keyed = '0;
		marked = '0;
		w43 = '0;
		x43 = '0;
		gw = '0;
		gh = '0;
		gx = '0;
		gy = '0;
		px = '0;
		py = '0;
		on_edge = 1'b0;
		grat_hit = 1'b0;
		box_hit = 1'b0;
		key_on = 1'b0;
		ramp = '0;
		loss = 1'b0;
		st_nxt = st_r;
		for (int i = 0; i < `VO_PATHS; i++) begin
			// Two-stage synchroniser on the loss pin
			st_nxt.p[i].loss_meta = input_signal_loss[i];
			st_nxt.p[i].loss_sync = st_r.p[i].loss_meta;
			loss = st_r.p[i].loss_sync;
			px = prog_pos[i].x;
			py = prog_pos[i].y;

			// Keyer decision and alpha per mode
			unique case (ovl_cfg[i].key_mode)
				VO_KEY_THRESH: begin
					key_on = key_pix[i].luma > ovl_cfg[i].key_threshold; // R12
					ramp = ovl_cfg[i].key_alpha; // R13
				end
				VO_KEY_REV: begin
					key_on = key_pix[i].luma < ovl_cfg[i].key_threshold; // R14
					ramp = ovl_cfg[i].key_alpha; // R13
				end
				VO_KEY_RAMP: begin
					// Alpha follows key luma, scaled by setting
					key_on = 1'b1; // R14
					ramp = `VO_ALPHA_W'(({9'h000, key_pix[i].luma} *
						{10'h000, ovl_cfg[i].key_alpha}) >> `VO_PIX_W);
				end
				VO_KEY_OFF: begin
					key_on = 1'b0;
					ramp = '0;
				end
			endcase
			keyed = prog_pix[i];
			if (key_on) begin
				keyed.luma = blend(prog_pix[i].luma, fill_pix[i].luma,
					ramp); // R13
				keyed.chroma = blend(prog_pix[i].chroma,
					fill_pix[i].chroma, ramp);
			end

			// Graticule inside the centred 4:3 area
			w43 = `VO_COORD_W'((raster[i].height * 4) / 3);
			if (w43 > raster[i].width) begin
				w43 = raster[i].width;
			end
			x43 = (raster[i].width - w43) >> 1;
			gw = scale_pct(w43, ovl_cfg[i].saa_width_pct); // R5
			gh = scale_pct(raster[i].height, ovl_cfg[i].saa_height_pct);
			gx = x43 + ((w43 - gw) >> 1); // R5
			gy = (raster[i].height - gh) >> 1;
			on_edge = (px == gx) || (px == gx + gw - 1'b1) ||
				(py == gy) || (py == gy + gh - 1'b1);
			grat_hit = ovl_cfg[i].saa_en && on_edge && (gw != '0) &&
				(gh != '0) && in_rect(px, py, gx, gy, gw, gh); // R4

			// Box only when enabled and loss rule allows
			box_hit = box_cfg[i].enable &&
				(!box_cfg[i].only_on_loss || loss) && // R6
				in_rect(px, py, box_org[i].width, box_org[i].height,
					box_sz[i].width, box_sz[i].height);

			// Markers layered on keyed picture; both may show
			marked = keyed;
			if (box_hit) begin
				marked = box_cfg[i].color; // R10
			end
			if (grat_hit) begin
				marked.luma = `VO_GRAT_LUMA; // R3
				marked.chroma = `VO_GRAT_CHROMA;
			end

			// Digital output, own master gate
			st_nxt.p[i].sdi_pos = prog_pos[i];
			st_nxt.p[i].sdi_pix = ovl_cfg[i].sdi_master_en ? marked :
				keyed; // R1 R2
			// Composite output, own master gate
			st_nxt.p[i].cv_pos = prog_pos[i];
			st_nxt.p[i].cv_pix = ovl_cfg[i].composite_video_output_master_en ? marked :
				keyed; // R1 R2

			// Loss with outputs disabled: no raster, no box
			if (loss && ovl_cfg[i].loss_disables_out) begin
				st_nxt.p[i].sdi_pos.valid = 1'b0; // R8
				st_nxt.p[i].cv_pos.valid = 1'b0; // R8
				st_nxt.p[i].sdi_pix.luma = `VO_BLANK_LUMA;
				st_nxt.p[i].sdi_pix.chroma = `VO_BLANK_CHROMA;
				st_nxt.p[i].cv_pix.luma = `VO_BLANK_LUMA;
				st_nxt.p[i].cv_pix.chroma = `VO_BLANK_CHROMA;
			end
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		for (int i = 0; i < `VO_PATHS; i++) begin
			sdi_pix[i] = st_r.p[i].sdi_pix;
			sdi_pos[i] = st_r.p[i].sdi_pos;
			composite_video_output_pix[i] = st_r.p[i].cv_pix;
			composite_video_output_pos[i] = st_r.p[i].cv_pos;
			loss_seen[i] = st_r.p[i].loss_sync;
		end
	end
endmodule

/* sim/vo_video_src.sv */
// Upstream source model: raster walk with program, key and fill streams
`timescale 1ns/1ps
module vo_video_src
	import vo_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Streams toward the inserter
	output vo_pix_s prog_pix [`VO_PATHS],
	output vo_pos_s prog_pos [`VO_PATHS],
	output vo_pix_s key_pix [`VO_PATHS],
	output vo_pix_s fill_pix [`VO_PATHS]
);
	logic [3:0] x_r = 4'h0; // Pixel within line, 16 wide
	logic [3:0] y_r = 4'h0; // Line within frame, 12 high
	logic rn; // Reset as seen at the edge, avoids a race
	// Step one pixel a cycle, shortly after the edge
	always @(posedge core_clk) begin
		rn = reset_n;
		#1;
		if (!rn) begin
			x_r = 4'h0;
			y_r = 4'h0;
		end else if (x_r != 4'hF) begin
			x_r = x_r + 4'h1;
		end else begin
			x_r = 4'h0;
			y_r = (y_r == 4'hB) ? 4'h0 : y_r + 4'h1;
		end
	end
	// Every pixel differs, so a stale or swapped sample shows
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			prog_pos[p] = '{1'b1, x_r == 0 && y_r == 0, {8'h00, x_r},
				{8'h00, y_r}};
			prog_pix[p] = '{{2'(p), y_r, x_r}, {x_r, y_r, 2'h1}};
			// Key luma spans below and above the thresholds used
			key_pix[p] = '{{y_r[1:0], x_r, 4'h0}, 10'h200};
			fill_pix[p] = '{{~x_r, 6'h15}, {y_r, 6'h2A}};
		end
	end
endmodule

/* sim/vo_overlay_inserter_sva.sv */
// Port checker of the overlay inserter, path zero
`timescale 1ns/1ps
module vo_overlay_sva
	import vo_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Watched inputs
	input wire vo_pix_s prog_pix [`VO_PATHS],
	input wire vo_pos_s prog_pos [`VO_PATHS],
	input wire vo_pix_s key_pix [`VO_PATHS],
	input wire vo_pix_s fill_pix [`VO_PATHS],
	input wire logic input_signal_loss [`VO_PATHS],
	input wire vo_ovl_cfg_s ovl_cfg [`VO_PATHS],
	input wire vo_box_cfg_s box_cfg [`VO_PATHS],
	// Watched outputs
	input wire vo_pix_s sdi_pix [`VO_PATHS],
	input wire vo_pos_s sdi_pos [`VO_PATHS],
	input wire vo_pix_s composite_video_output_pix [`VO_PATHS],
	input wire vo_pos_s composite_video_output_pos [`VO_PATHS],
	input wire logic loss_seen [`VO_PATHS]
);
	logic live_r; // Reset already high one edge ago
	logic blank0; // Loss blanks path zero
	logic plain0; // Keyer off, no blanking
	logic key0; // Full alpha, no marker can land
	// First edge after release is left alone
	always_ff @(posedge core_clk) begin
		live_r <= reset_n;
	end
	assign blank0 = loss_seen[0] && ovl_cfg[0].loss_disables_out;
	assign plain0 = live_r && !blank0 && ovl_cfg[0].key_mode == VO_KEY_OFF;
	assign key0 = live_r && !loss_seen[0] && !ovl_cfg[0].saa_en
		&& !box_cfg[0].enable && ovl_cfg[0].key_alpha == `VO_ALPHA_FULL;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Loss pin rises and is held a second edge
	sequence s_loss_rise;
		!loss_seen[0] && $rose(input_signal_loss[0]) ##1 input_signal_loss[0];
	endsequence
	property p_sdi_pass;
		plain0 && !ovl_cfg[0].sdi_master_en |=> sdi_pix[0] == $past(prog_pix[0]);
	endproperty
	a_sdi_pass: assert property (p_sdi_pass)
		else $error("digital output not plain program");
	property p_composite_video_output_pass;
		plain0 && !ovl_cfg[0].composite_video_output_master_en
			|=> composite_video_output_pix[0] == $past(prog_pix[0]);
	endproperty
	a_composite_video_output_pass: assert property (p_composite_video_output_pass)
		else $error("composite output not plain program");
	property p_pos_follow;
		live_r && !blank0 |=> sdi_pos[0] == $past(prog_pos[0]);
	endproperty
	a_pos_follow: assert property (p_pos_follow)
		else $error("digital position not one cycle behind");
	property p_loss_blank;
		blank0 |=> !sdi_pos[0].valid && !composite_video_output_pos[0].valid
			&& sdi_pix[0] == {`VO_BLANK_LUMA, `VO_BLANK_CHROMA};
	endproperty
	a_loss_blank: assert property (p_loss_blank)
		else $error("output not blanked on loss");
	property p_loss_sync;
		s_loss_rise |-> !loss_seen[0] ##1 loss_seen[0];
	endproperty
	a_loss_sync: assert property (p_loss_sync)
		else $error("loss status not two edges behind pin");
	property p_key_fill;
		key0 && ovl_cfg[0].key_mode == VO_KEY_THRESH
			&& key_pix[0].luma > ovl_cfg[0].key_threshold
			|=> sdi_pix[0] == $past(fill_pix[0]);
	endproperty
	a_key_fill: assert property (p_key_fill)
		else $error("key above threshold did not show fill");
	property p_key_rev;
		key0 && ovl_cfg[0].key_mode == VO_KEY_REV
			&& key_pix[0].luma < ovl_cfg[0].key_threshold
			|=> sdi_pix[0] == $past(fill_pix[0]);
	endproperty
	a_key_rev: assert property (p_key_rev)
		else $error("reverse key below threshold did not show fill");
	property p_key_hold;
		key0 && ovl_cfg[0].key_mode == VO_KEY_THRESH
			&& key_pix[0].luma <= ovl_cfg[0].key_threshold
			|=> sdi_pix[0] == $past(prog_pix[0]);
	endproperty
	a_key_hold: assert property (p_key_hold)
		else $error("key at or below threshold replaced program");
endmodule

bind vo_overlay_inserter vo_overlay_sva u_sva (.core_clk, .reset_n,
	.prog_pix, .prog_pos, .key_pix, .fill_pix, .input_signal_loss,
	.ovl_cfg, .box_cfg, .sdi_pix, .sdi_pos, .composite_video_output_pix,
	.composite_video_output_pos, .loss_seen);

/* sim/vo_overlay_inserter_tb.sv */
// Self-checking bench of the two-path overlay inserter
`timescale 1ns/1ps
module vo_overlay_inserter_tb;
	import vo_pkg::*;
	logic core_clk = 1'b0; // 200 MHz pixel clock
	logic reset_n = 1'b0; // Held low at start
	vo_raster_s raster [`VO_PATHS]; // Format, 16 by 12
	vo_pix_s prog_pix [`VO_PATHS], key_pix [`VO_PATHS], fill_pix [`VO_PATHS];
	vo_pix_s pp [`VO_PATHS], kk [`VO_PATHS], ff [`VO_PATHS]; // Taken inputs
	vo_pos_s prog_pos [`VO_PATHS], sdi_pos [`VO_PATHS];
	vo_pos_s composite_video_output_pos [`VO_PATHS];
	vo_pix_s sdi_pix [`VO_PATHS], composite_video_output_pix [`VO_PATHS];
	logic input_signal_loss [`VO_PATHS], loss_seen [`VO_PATHS];
	vo_ovl_cfg_s ovl_cfg [`VO_PATHS]; // Overlay settings
	vo_box_cfg_s box_cfg [`VO_PATHS]; // Box settings
	int error_cnt = 0, n_compared = 0, cyc = 0;
	vo_video_src src (.core_clk, .reset_n, .prog_pix, .prog_pos, .key_pix,
		.fill_pix);
	vo_overlay_inserter dut (.core_clk, .reset_n, .raster, .prog_pix,
		.prog_pos, .key_pix, .fill_pix, .input_signal_loss, .ovl_cfg,
		.box_cfg, .sdi_pix, .sdi_pos, .composite_video_output_pix,
		.composite_video_output_pos, .loss_seen);
	// Clock, 5 ns period
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	// What the design took at each edge; hang guard
	always @(posedge core_clk) begin
		pp <= prog_pix;
		kk <= key_pix;
		ff <= fill_pix;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Inputs change 1 ns after the edge
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	// Bounded wait for a pixel on the digital output of path zero
	task automatic wait_at(int x, int y);
		int n;
		n = 0;
		while (!(sdi_pos[0].valid === 1'b1 && sdi_pos[0].x === 12'(x)
			&& sdi_pos[0].y === 12'(y)) && n < 500) begin
			step();
			n++;
		end
		check("pixel reached", 20'(n < 500), 20'h1);
	endtask
	// Keyed pixel worked out from mode, threshold and alpha
	function automatic vo_pix_s key_exp(vo_key_mode_e m, logic [9:0] thr,
		logic [8:0] al, vo_pix_s p, vo_pix_s k, vo_pix_s f);
		int a;
		case (m)
			VO_KEY_THRESH: a = (k.luma > thr) ? al : 0;
			VO_KEY_REV: a = (k.luma < thr) ? al : 0;
			VO_KEY_RAMP: a = (k.luma * al) >> 10;
			default: a = 0;
		endcase
		key_exp.luma = 10'((p.luma * (256 - a) + f.luma * a) >> 8);
		key_exp.chroma = 10'((p.chroma * (256 - a) + f.chroma * a) >> 8);
	endfunction
	// Every mode at two alphas and two thresholds; path one stays plain
	task automatic t_key();
		vo_pix_s e;
		vo_key_mode_e m;
		for (int i = 0; i < 16; i++) begin
			m = vo_key_mode_e'(i[1:0]);
			ovl_cfg[0].key_mode = m;
			ovl_cfg[0].key_alpha = i[2] ? 9'h080 : `VO_ALPHA_FULL;
			ovl_cfg[0].key_threshold = i[3] ? 10'h100 : 10'h200;
			step();
			repeat (40) begin
				step();
				e = key_exp(m, ovl_cfg[0].key_threshold, ovl_cfg[0].key_alpha,
					pp[0], kk[0], ff[0]);
				check("digital keyed", sdi_pix[0], e);
				check("composite keyed", composite_video_output_pix[0], e);
				check("path one", sdi_pix[1], pp[1]);
			end
		end
		ovl_cfg[0].key_mode = VO_KEY_OFF;
	endtask
	// Graticule on digital only, then its own enable cleared
	task automatic t_saa();
		ovl_cfg[0] = '0;
		ovl_cfg[0].saa_en = 1'b1;
		ovl_cfg[0].saa_height_pct = `VO_PCT_FULL;
		ovl_cfg[0].saa_width_pct = `VO_PCT_FULL;
		ovl_cfg[0].sdi_master_en = 1'b1;
		wait_at(0, 0);
		check("outline", sdi_pix[0], {`VO_GRAT_LUMA, `VO_GRAT_CHROMA});
		check("composite masked", composite_video_output_pix[0], pp[0]);
		wait_at(5, 5);
		check("inside outline", sdi_pix[0], pp[0]);
		ovl_cfg[0].saa_en = 1'b0;
		wait_at(0, 0);
		check("graticule off", sdi_pix[0], pp[0]);
	endtask
	// Still box at origin with graticule, then insertion on loss only
	task automatic t_box();
		do_reset();
		box_cfg[0] = '{1'b1, 1'b0, 7'h64, 7'h28, 4'h0, 4'h0,
			'{10'h111, 10'h222}};
		ovl_cfg[0].saa_en = 1'b1;
		wait_at(0, 0);
		check("outline over box", sdi_pix[0], {`VO_GRAT_LUMA, `VO_GRAT_CHROMA});
		wait_at(2, 2);
		check("box colour", sdi_pix[0], 20'h4_4622);
		wait_at(6, 2);
		check("box width clamp", sdi_pix[0], pp[0]);
		wait_at(2, 4);
		check("box height", sdi_pix[0], pp[0]);
		box_cfg[0].only_on_loss = 1'b1;
		wait_at(2, 2);
		check("box waits for loss", sdi_pix[0], pp[0]);
		input_signal_loss[0] = 1'b1;
		repeat (3) step();
		check("loss seen", loss_seen[0], 1'b1);
		wait_at(2, 2);
		check("box on loss", sdi_pix[0], 20'h4_4622);
		ovl_cfg[0].loss_disables_out = 1'b1;
		repeat (2) step();
		check("no raster", sdi_pos[0].valid, 1'b0);
		check("blank", sdi_pix[0], {`VO_BLANK_LUMA, `VO_BLANK_CHROMA});
		check("no composite", composite_video_output_pos[0].valid, 1'b0);
		check("other path", sdi_pos[1].valid, 1'b1);
		input_signal_loss[0] = 1'b0;
		ovl_cfg[0].loss_disables_out = 1'b0;
		repeat (4) step();
	endtask
	// Box moves 3 and 2 per frame, bounces; box 6 by 4 on 16 by 12
	task automatic t_move();
		int xs [6] = '{3, 6, 9, 10, 7, 4};
		int ys [6] = '{2, 4, 6, 8, 6, 4};
		box_cfg[0].only_on_loss = 1'b0;
		box_cfg[0].speed_x = 4'h3;
		box_cfg[0].speed_y = 4'h2;
		for (int f = 0; f < 6; f++) begin
			wait_at(0, 0);
			wait_at(xs[f] - 1, ys[f]);
			check("left of box", sdi_pix[0], pp[0]);
			wait_at(xs[f], ys[f]);
			check("box moved", sdi_pix[0], 20'h4_4622);
			check("composite no box", composite_video_output_pix[0], pp[0]);
			check("composite x", composite_video_output_pos[0].x, 20'(xs[f]));
			check("path one no box", sdi_pix[1], pp[1]);
		end
	endtask
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (10) step();
		reset_n = 1'b1;
	endtask
	// Main sequence
	initial begin
		for (int p = 0; p < 2; p++) begin
			raster[p] = '{12'h010, 12'h00C};
			input_signal_loss[p] = 1'b0;
			ovl_cfg[p] = '0;
			box_cfg[p] = '0;
		end
		do_reset();
		t_key();
		t_saa();
		t_box();
		t_move();
		tally_and_finish();
	end
endmodule
